// ---- hw/rsd_dma_port.sv ----
// Shared-memory bus-master transfer port with host register index capture
`timescale 1ns/1ps
module rsd_dma_port (
  input  wire logic                     i_mclk,
  input  wire logic                     i_reset,
  // Transfer requests from the protocol engine
  input  wire logic                     i_xfer_valid,
  output      logic                     o_xfer_ready,
  input  wire rsd_pkg::rsd_xfer_s       i_xfer,
  // Fetched words back to the protocol engine
  output      logic                     o_rdata_valid,
  output      logic [rsd_pkg::DATA_W-1:0] o_rdata,
  output      logic                     o_busy,
  // Bus arbitration
  output      logic                     o_bus_request_n,
  input  wire logic                     i_bus_grant_n,
  input  wire logic                     i_bus_access_enable,
  // Shared address bus, low three bits two-way
  output      logic [rsd_pkg::ADDR_W-1:0] o_shared_addr,
  output      logic [rsd_pkg::ADDR_W-1:0] o_shared_addr_oe,
  input  wire logic [rsd_pkg::REG_IDX_W-1:0] i_shared_addr_lo,
  // Shared data bus
  input  wire logic [rsd_pkg::DATA_W-1:0] i_shared_data,
  output      logic [rsd_pkg::DATA_W-1:0] o_shared_data,
  output      logic                     o_shared_data_oe,
  // Three-state memory strobes
  output      logic                     o_addr_valid_n,
  output      logic                     o_addr_valid_oe,
  output      logic                     o_ram_read_strobe_n,
  output      logic                     o_ram_read_strobe_oe,
  output      logic                     o_ram_store_strobe_n,
  output      logic                     o_ram_store_strobe_oe,
  // Host register access pins
  input  wire logic                     i_chip_select_n,
  input  wire logic                     i_reg_read_n,
  input  wire logic                     i_reg_store_n,
  output      logic                     o_reg_access_valid,
  output      rsd_pkg::rsd_regacc_s     o_reg_access
);

  // ****************************************
  // Theory of operation
  // ****************************************
  // A transfer request waits in the buffer until the port is idle and
  // the host has enabled access. The port then lowers its request and
  // waits for a grant that counts only while access is enabled.
  // One granted cycle runs: a single clock with the address and its
  // valid strobe out, then the fetch or store strobe for a fixed
  // number of clocks, then one clock with every pin released.
  // A fetched word is taken at the last strobe edge and handed back
  // the clock after, together with a one-cycle valid pulse.
  // Dropping the access enable in mid-cycle floats the pins at once,
  // combinationally, because the host may already be driving the bus.
  // The entry stays at the head of the buffer and is simply retried,
  // so no transfer is lost; the price is that a store whose strobe
  // was cut short may be written a second time with the same word.
  // The grant is taken to stay low until the address strobe has
  // returned high; the port does not watch for an early withdrawal.
  // Register accesses from the host are only captured here: the index
  // on the low address lines, the strobes and the data word are
  // registered for the register file, which lives elsewhere.
  // Captures are suppressed while the port itself drives the bus,
  // since the low address lines then carry the memory address.
  // Limitation: one transfer at a time, at least six clocks apiece,
  // plus whatever the host spends before granting.

  // ****************************************
  // Request buffer
  // ****************************************
  logic              fifo_valid;
  logic              fifo_ready;
  rsd_pkg::rsd_xfer_s fifo_data;

  // Back-pressure reaches the engine through o_xfer_ready
  rsd_fifo #(
    .WIDTH ($bits(rsd_pkg::rsd_xfer_s)),
    .DEPTH (rsd_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_in_valid  (i_xfer_valid),
    .o_in_ready  (o_xfer_ready),
    .i_in_data   (i_xfer),
    .o_out_valid (fifo_valid),
    .i_out_ready (fifo_ready),
    .o_out_data  (fifo_data)
  );

  // ****************************************
  // Transfer state machine
  // ****************************************
  rsd_pkg::rsd_state_e state_q, state_d;
  rsd_pkg::rsd_xfer_s  cur_q;
  logic [3:0]          cnt_q;
  logic [rsd_pkg::DATA_W-1:0] rdata_q;
  logic                rvalid_q;

  // State decode shared by the counter, pop and pin logic
  wire st_idle   = (state_q == rsd_pkg::ST_IDLE);
  wire st_req    = (state_q == rsd_pkg::ST_REQ);
  wire st_addr   = (state_q == rsd_pkg::ST_ADDR);
  wire st_strobe = (state_q == rsd_pkg::ST_STROBE);

  wire grant   = ~i_bus_grant_n & i_bus_access_enable;
  wire enable  = i_bus_access_enable;
  // Last strobe clock; the counter runs only in the strobe state
  wire cnt_end = (cnt_q == rsd_pkg::STROBE_CNT_W - 4'h1);
  wire in_cyc  = st_addr | st_strobe;

  // Next state; enable low aborts a cycle back to request, then to idle, so no cycle runs unenabled
  always_comb begin
    state_d = state_q;
    case (state_q)
      rsd_pkg::ST_IDLE: begin
        if (fifo_valid && enable) state_d = rsd_pkg::ST_REQ;
      end
      rsd_pkg::ST_REQ: begin
        if (!enable) begin
          state_d = rsd_pkg::ST_IDLE;
        end else if (grant) begin
          state_d = rsd_pkg::ST_ADDR;
        end
      end
      rsd_pkg::ST_ADDR: begin
        state_d = enable ? rsd_pkg::ST_STROBE : rsd_pkg::ST_REQ;
      end
      rsd_pkg::ST_STROBE: begin
        if (!enable) begin
          state_d = rsd_pkg::ST_REQ;
        end else if (cnt_end) begin
          state_d = rsd_pkg::ST_RELEASE;
        end
      end
      rsd_pkg::ST_RELEASE: state_d = rsd_pkg::ST_IDLE;
      default:             state_d = rsd_pkg::ST_IDLE;
    endcase
  end

  // Entry popped only when the cycle completed
  assign fifo_ready = st_strobe & enable & cnt_end;

  // State, strobe counter and current entry
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= rsd_pkg::ST_IDLE;
      cnt_q   <= 4'h0;
      cur_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= st_strobe ? cnt_q + 4'h1 : 4'h0;
      if (st_idle) cur_q <= fifo_data;
    end
  end

  // Fetched word captured at the trailing strobe edge
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= fifo_ready & ~cur_q.write;
      if (fifo_ready && !cur_q.write) rdata_q <= i_shared_data;
    end
  end
  assign o_rdata_valid = rvalid_q;
  assign o_rdata       = rdata_q;
  assign o_busy        = ~st_idle;

  // ****************************************
  // Pin drive
  // ****************************************
  // request held from before the cycle until it ends
  // request dropped after the strobe cycle
  assign o_bus_request_n = ~(st_req | in_cyc);

  // Enables and strobes come straight from the state register and the
  // enable pin, so a withdrawn enable floats the pins in the same clock
  // everything floats while enable is low
  wire drive = in_cyc & enable;
  wire strb  = st_strobe;

  // full address driven, low lines released otherwise for host index
  assign o_shared_addr    = cur_q.addr;
  assign o_shared_addr_oe = {rsd_pkg::ADDR_W{drive}};
  // address valid throughout the driven cycle
  assign o_addr_valid_n   = ~drive;
  assign o_addr_valid_oe  = drive;
  assign o_ram_read_strobe_n   = ~(strb & ~cur_q.write);
  assign o_ram_read_strobe_oe  = drive;
  assign o_ram_store_strobe_n  = ~(strb & cur_q.write);
  assign o_ram_store_strobe_oe = drive;
  assign o_shared_data    = cur_q.data;
  assign o_shared_data_oe = drive & cur_q.write;
  // grant is taken as held until address strobe returns high

  // ****************************************
  // Host register access capture
  // ****************************************
  // select with read or store strobe; low address lines give index
  wire reg_hit = ~i_chip_select_n & (~i_reg_read_n | ~i_reg_store_n);
  // Register access word as seen on the pins this clock
  wire rsd_pkg::rsd_regacc_s reg_word = '{rd: ~i_reg_read_n, wr: ~i_reg_store_n,
                                          idx: i_shared_addr_lo, data: i_shared_data};
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      o_reg_access_valid <= 1'b0;
      o_reg_access       <= '0;
    end else begin
      o_reg_access_valid <= reg_hit & ~drive;
      o_reg_access       <= reg_word;
    end
  end
endmodule : rsd_dma_port

// ---- hw/rsd_fifo.sv ----
// Parameterised valid/ready FIFO held in flip-flops
`timescale 1ns/1ps
module rsd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output      logic             o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output      logic             o_out_valid,
  input  wire logic             i_out_ready,
  output      logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wr_q;
  logic [PW-1:0]    rd_q;
  logic [PW:0]      cnt_q;
  wire              push = i_in_valid & o_in_ready;
  wire              pop  = o_out_valid & i_out_ready;

  // Honest flags from the fill count
  assign o_in_ready  = (cnt_q != (PW+1)'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data  = mem_q[rd_q];

  // Pointers and count
  always_ff @(posedge i_mclk or posedge i_reset) begin
    if (i_reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == PW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop)  rd_q <= (rd_q == PW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (PW+1)'(push) - (PW+1)'(pop);
    end
  end

  // Storage, written without reset
  always_ff @(posedge i_mclk) begin
    if (push) mem_q[wr_q] <= i_in_data;
  end
endmodule : rsd_fifo

// ---- inc/rsd_pkg.sv ----
// Package of constants and carrier types for the shared-memory transfer port
// Overview of operation
// - Data bus 16 bits, two-way, released otherwise
// - Device drives 16-bit memory address, three-state
// - Low three address lines carry register index
// - Assert bus request before any memory transfer
// - Grant counts only while access enable high
// - Enable low floats pins, blocks access cycles
// - Address valid strobe low while address valid
// - Read strobe low during memory fetch cycles
// - Store strobe low during memory store cycles
package rsd_pkg;

  // ****************************************
  // Widths and sizes
  // ****************************************
  localparam int DATA_W     = 16;
  localparam int ADDR_W     = 16;
  localparam int REG_IDX_W  = 3;
  localparam int FIFO_DEPTH = 8;

  // ****************************************
  // Timing (ns) and derived cycle counts
  // ****************************************
  localparam int CLK_PERIOD_NS   = 5;
  localparam int STROBE_NS       = 10;  // Least width of read/store strobe
  localparam int STROBE_CYCLES   = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] STROBE_CNT_W = 4'(STROBE_CYCLES);

  // ****************************************
  // Carrier types
  // ****************************************
  // One memory transfer request from the protocol engine side
  typedef struct packed {
    logic              write;   // 1: store into host memory, 0: fetch
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } rsd_xfer_s;

  // Host register access seen by the device
  typedef struct packed {
    logic                 rd;
    logic                 wr;
    logic [REG_IDX_W-1:0] idx;
    logic [DATA_W-1:0]    data;
  } rsd_regacc_s;

  // Transfer state machine, one-hot
  typedef enum logic [4:0] {
    ST_IDLE    = 5'h01,
    ST_REQ     = 5'h02,
    ST_ADDR    = 5'h04,
    ST_STROBE  = 5'h08,
    ST_RELEASE = 5'h10
  } rsd_state_e;

endpackage : rsd_pkg

// ---- verification/rsd_dma_port_sva.sv ----
// Checker of the transfer port arbitration and strobe timing
`timescale 1ns/1ps
module rsd_dma_port_sva (
  input wire logic                       i_mclk,
  input wire logic                       i_reset,
  input wire logic                       i_bus_grant_n,
  input wire logic                       i_bus_access_enable,
  input wire logic                       o_bus_request_n,
  input wire logic [rsd_pkg::ADDR_W-1:0] o_shared_addr_oe,
  input wire logic                       o_shared_data_oe,
  input wire logic                       o_addr_valid_n,
  input wire logic                       o_addr_valid_oe,
  input wire logic                       o_ram_read_strobe_n,
  input wire logic                       o_ram_read_strobe_oe,
  input wire logic                       o_ram_store_strobe_n,
  input wire logic                       o_ram_store_strobe_oe,
  input wire logic                       o_rdata_valid
);
  // ****************************************
  // Port rules
  // ****************************************
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  wire en = i_bus_access_enable;
  AST_FLOAT: assert property (!en |-> o_shared_addr_oe == '0 && !o_shared_data_oe && !o_addr_valid_oe
    && !o_ram_read_strobe_oe && !o_ram_store_strobe_oe) else $error("pins driven while disabled");
  AST_NO_START: assert property (!en && o_bus_request_n |=> o_bus_request_n)
    else $error("request raised while disabled");
  AST_REQ_FIRST: assert property ($rose(o_addr_valid_oe) |-> !$past(o_bus_request_n))
    else $error("cycle without request");
  AST_GRANT_EN: assert property ($rose(o_addr_valid_oe) |-> !$past(i_bus_grant_n) && $past(en))
    else $error("cycle without enabled grant");
  AST_ADDR_DRIVE: assert property (o_addr_valid_oe |-> !o_addr_valid_n && &o_shared_addr_oe)
    else $error("address strobe without address");
  AST_RD_STROBE: assert property (o_ram_read_strobe_oe && !o_ram_read_strobe_n |-> o_addr_valid_oe
    && !o_shared_data_oe && o_ram_store_strobe_n) else $error("bad fetch strobe");
  AST_ST_DATA: assert property (o_ram_store_strobe_oe && !o_ram_store_strobe_n |-> o_shared_data_oe
    && o_addr_valid_oe && o_ram_read_strobe_n) else $error("bad store strobe");
  AST_RD_DONE: assert property ($fell(o_ram_read_strobe_oe) && en && !$past(o_ram_read_strobe_n)
    |-> o_rdata_valid) else $error("fetch without data");
  AST_RELEASE: assert property ($fell(o_addr_valid_oe) && en |-> o_bus_request_n ##1 !o_addr_valid_oe)
    else $error("no release after cycle");
  // Main scenarios reached
  cover property ($fell(o_ram_read_strobe_oe) && o_rdata_valid);
  cover property ($rose(o_ram_store_strobe_oe));
  cover property ($fell(en) && !o_bus_request_n);
endmodule : rsd_dma_port_sva

bind rsd_dma_port rsd_dma_port_sva u_rsd_dma_port_sva (.*);

// ---- verification/rsd_dma_port_tb.sv ----
// Testbench of the shared-memory transfer port
`timescale 1ns/1ps
module rsd_dma_port_tb;
  logic                 clk = 0, rst = 1, vld = 0, en = 0, cs_n = 1, rr_n = 1, rs_n = 1;
  logic [2:0]           idx = 0, alo;
  logic [15:0]          sh [16], exp_q[$], hd, sa, sd, od, rdata;
  logic [15:0]          sao;
  logic                 gnt_n, req_n, rdy, busy, dv, doe, avo, rso, rsn, sso, ssn, rav;
  rsd_pkg::rsd_xfer_s   x = '0;
  rsd_pkg::rsd_regacc_s ra;
  int                   errors = 0, check_count = 0, seed = 85640, i, n, m;
  always #2.5 clk = ~clk;
  assign alo = sao[0] ? sa[2:0] : idx;
  assign sd = doe ? od : hd;
  rsd_dma_port u_rsd_dma_port (.i_mclk(clk), .i_reset(rst), .i_xfer_valid(vld), .o_xfer_ready(rdy), .i_xfer(x),
    .o_rdata_valid(dv), .o_rdata(rdata), .o_busy(busy), .o_bus_request_n(req_n), .i_bus_grant_n(gnt_n),
    .i_bus_access_enable(en), .o_shared_addr(sa), .o_shared_addr_oe(sao), .i_shared_addr_lo(alo),
    .i_shared_data(sd), .o_shared_data(od), .o_shared_data_oe(doe), .o_addr_valid_n(), .o_addr_valid_oe(avo),
    .o_ram_read_strobe_n(rsn), .o_ram_read_strobe_oe(rso), .o_ram_store_strobe_n(ssn),
    .o_ram_store_strobe_oe(sso), .i_chip_select_n(cs_n), .i_reg_read_n(rr_n), .i_reg_store_n(rs_n),
    .o_reg_access_valid(rav), .o_reg_access(ra));
  rsd_host_model u_rsd_host_model (.i_mclk(clk), .i_req_n(req_n), .i_rd_n(!rso | rsn), .i_st_n(!sso | ssn),
    .i_addr(sa), .i_data(sd), .o_grant_n(gnt_n), .o_data(hd));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    check_count++;
    if (e !== g) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Pushes one transfer, held until taken; expectation follows FIFO order
  task automatic push(logic w, logic [15:0] a, logic [15:0] d);
    @(negedge clk);
    x = '{w, a, d};
    vld = 1;
    n = 0;
    do @(posedge clk); while (!rdy && ++n < 200);
    if (w) sh[a[3:0]] = d;
    else exp_q.push_back(sh[a[3:0]]);
  endtask : push
  // Waits for the port to go quiet with every fetch answered
  task automatic drain;
    @(negedge clk) vld = 0;
    n = 0;
    m = 0;
    while (n++ < 900 && (m < 8 || exp_q.size())) @(negedge clk) m = busy ? 0 : m + 1;
    chk("drain", 1, n < 900);
  endtask : drain
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish
  // Every fetched word against the shadow memory
  always @(negedge clk) if (dv) begin
    if (exp_q.size() == 0) chk("extra word", 0, 1);
    else chk("fetched word", exp_q.pop_front(), rdata);
  end
  initial begin
    #(20000 * 5);
    chk("watchdog", 0, 1);
    tally_and_finish();
  end
  initial begin
    for (i = 0; i < 16; i++) sh[i] = {12'hc3a, 4'(i)};
    repeat (12) @(posedge clk);
    @(negedge clk) rst = 0;
    for (i = 0; i < 8; i++) push(!i[0], 16'h4a30 + 16'(i >> 1), 16'($random(seed)));
    @(negedge clk) vld = 0;
    chk("ready when full", 0, rdy);
    chk("request while disabled", 1, req_n);
    en = 1;
    drain();
    for (i = 0; i < 40; i++) push(1'($random(seed)), 16'($random(seed)), 16'($random(seed)));
    drain();
    push(0, 16'h0005, 0);
    @(negedge clk) vld = 0;
    n = 0;
    while (!avo && n++ < 50) @(negedge clk);
    en = 0;
    #1 chk("floated when disabled", 0, {sao, doe, avo, rso, sso});
    repeat (3) @(negedge clk);
    en = 1;
    drain();
    chk("request after release", 1, req_n);
    for (i = 0; i < 16; i++) begin
      idx = 3'(i);
      cs_n = 0;
      rr_n = i[3];
      rs_n = !i[3];
      @(negedge clk) chk("register access", {2'b11, !i[3], i[3], 3'(i)}, {rav, req_n, ra.rd, ra.wr, ra.idx});
      chk("register data", 16'(~hd), ra.data);
      cs_n = 1;
      @(negedge clk);
    end
    tally_and_finish();
  end
endmodule : rsd_dma_port_tb

// ---- verification/rsd_host_model.sv ----
// Host side model: bus arbiter and 16-word shared memory
`timescale 1ns/1ps
module rsd_host_model (
  input  wire logic        i_mclk,
  input  wire logic        i_req_n,
  input  wire logic        i_rd_n,
  input  wire logic        i_st_n,
  input  wire logic [15:0] i_addr,
  input  wire logic [15:0] i_data,
  output      logic        o_grant_n,
  output      logic [15:0] o_data
);
  logic [15:0] mem [16];
  logic [15:0] pat = 16'h5aa5;
  logic [1:0]  dly = 2'h0;
  logic        slow = 1'b0;
  initial begin
    o_grant_n = 1'b1;
    for (int k = 0; k < 16; k++) mem[k] = {12'hc3a, 4'(k)};
  end
  // bus released: a changing pattern, not the last word
  assign o_data = !i_rd_n ? mem[i_addr[3:0]] : pat;
  // grant held until request drops after the strobe; waits alternate quick and slow
  always @(posedge i_mclk) begin
    pat <= ~pat;
    if (!i_st_n) mem[i_addr[3:0]] <= i_data;
    if (i_req_n) begin
      o_grant_n <= 1'b1;
      dly <= {slow, 1'b0};
      slow <= slow ^ !o_grant_n;
    end else if (dly != 2'h0) dly <= dly - 2'h1;
    else o_grant_n <= 1'b0;
  end
endmodule : rsd_host_model
